// ### pma_pkg.sv
// Shared constants and types for the program mode access timer
package pma_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int SEC_TIME_S = 1;
    localparam int SEC_CYCLES = CLK_HZ * SEC_TIME_S;
    localparam int PRESC_W = 25;

    localparam logic [7:0] ADDR_KEY_FUNC = 8'h00;
    localparam logic [7:0] ADDR_KEY_ENTER = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_TIMEOUT = 8'h0C;
    localparam logic [7:0] ADDR_DISPLAY = 8'h10;

    localparam int ST_MODE_LSB = 0;
    localparam int ST_LED_BIT = 2;
    localparam int ST_JUMPER_BIT = 3;
    localparam int ST_DIGITS_LSB = 4;
    localparam int ST_SHOWPOS_BIT = 7;
    localparam int ST_ERR_LSB = 8;

    localparam logic [9:0] FN_ACCESS = 10'h00A;
    localparam logic [9:0] FN_TIMEOUT = 10'h00B;
    localparam logic [9:0] FN_NEWCODE = 10'h05A;

    localparam logic [19:0] PROG_CODE_RST = 20'h0_0834;
    localparam logic [19:0] SUPV_CODE_DEF = 20'h5_1A3C;
    localparam logic [9:0] TMO_RST = 10'h078;
    localparam logic [9:0] TMO_MIN = 10'h00A;
    localparam logic [9:0] TMO_MAX = 10'h3E8;
    localparam logic [2:0] DIGITS_FULL = 3'h6;
    localparam logic [2:0] DIGITS_LOCKED = 3'h1;

    localparam logic [3:0] ERR_NONE = 4'h0;
    localparam logic [3:0] ERR_RANGE = 4'h3;
    localparam logic [3:0] ERR_LOCKED = 4'h7;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {MODE_NORMAL, MODE_PROGRAM, MODE_SUPERVISOR} pma_mode_t;
endpackage

// ### pma_sec_timer.sv
// Whole-second inactivity timer with restart and one-cycle expiry pulse
`timescale 1ns/1ps
module pma_sec_timer #(
    parameter int SEC_CYCLES = pma_pkg::SEC_CYCLES
) (
    // Clock, reset and enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Control
    input wire logic restart,
    input wire logic [9:0] timeout_s,
    output logic expire
);
    import pma_pkg::*;

    typedef struct packed {
        logic armed;
        logic [PRESC_W-1:0] presc;
        logic [9:0] secs;
        logic expire;
    } pma_tmr_st_t;

    pma_tmr_st_t st_r;
    pma_tmr_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.expire = 1'b0;
        if (restart) begin
            st_nxt.armed = 1'b1;
            st_nxt.presc = '0;
            st_nxt.secs = '0;
        end else if (st_r.armed) begin
            if (st_r.presc == PRESC_W'(SEC_CYCLES - 1)) begin
                st_nxt.presc = '0;
                if (st_r.secs + 10'h001 >= timeout_s) begin
                    st_nxt.armed = 1'b0;
                    st_nxt.expire = 1'b1;
                end else begin
                    st_nxt.secs = st_r.secs + 10'h001;
                end
            end else begin
                st_nxt.presc = st_r.presc + PRESC_W'(1);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign expire = st_r.expire;
endmodule

// ### pma_access_ctrl.sv
// Program/supervisory access control, lockout and inactivity time-out with AXI4-Lite slave
//
// How it works
// - Ordinary parameter changes pass only in program or supervisory mode
// - Program mode needs the lockout jumper fitted
// - Entry field six digits with jumper, else one
// - Function 10 with program code enters program mode
// - Supervisory code gives supervisory mode; supervisory-only functions
// - Non-matching access entry drops to normal mode
// - Function 90 replaces code only in supervisory mode
// - Key press restarts timer; expiry leaves program mode
// - Time-out set by function 11, 10..1000 s, 120 default
// - Expiry returns display to machine position
//
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module pma_access_ctrl #(
    parameter int SEC_CYCLES = pma_pkg::SEC_CYCLES,
    // Arbitrary value, replaced at build time
    parameter logic [19:0] SUPV_CODE = pma_pkg::SUPV_CODE_DEF
) (
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Lockout pin
    input wire logic program_lockout_jumper,
    // AXI4-Lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Indicator and display
    output logic program_led,
    output logic [2:0] entry_digits,
    output logic show_position,
    // Parameter store write port
    output logic param_wr_valid,
    output logic [9:0] param_func,
    output logic [19:0] param_data
);
    import pma_pkg::*;

    typedef struct packed {
        logic aw_hold;
        logic [7:0] awaddr;
        logic w_hold;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic sync_a;
        logic jumper_s;
        pma_mode_t mode;
        logic [9:0] func;
        logic [19:0] entry;
        logic [19:0] prog_code;
        logic [9:0] tmo;
        logic led;
        logic [2:0] digits;
        logic show_pos;
        logic [3:0] err;
        logic pv;
        logic [9:0] pfunc;
        logic [19:0] pdata;
        logic key;
    } pma_top_st_t;

    pma_top_st_t st_r;
    pma_top_st_t st_nxt;
    logic expire;
    logic entry_fire;
    logic [19:0] val;

    pma_sec_timer #(
        .SEC_CYCLES(SEC_CYCLES)
    ) u_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .restart(st_r.key),
        .timeout_s(st_r.tmo),
        .expire(expire)
    );

    always_comb begin
        st_nxt = st_r;
        entry_fire = 1'b0;
        val = '0;
        st_nxt.pv = 1'b0;
        st_nxt.key = 1'b0;
        // Two-stage synchroniser for the jumper pin
        st_nxt.sync_a = program_lockout_jumper;
        st_nxt.jumper_s = st_r.sync_a;
        st_nxt.digits = st_r.jumper_s ? DIGITS_FULL : DIGITS_LOCKED;

        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end
        if (s_axi_awvalid && st_r.awready) begin
            st_nxt.aw_hold = 1'b1;
            st_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_r.wready) begin
            st_nxt.w_hold = 1'b1;
            st_nxt.wdata = s_axi_wdata;
            st_nxt.wstrb = s_axi_wstrb;
        end

        // Write execution once address and data are both held
        if (st_nxt.aw_hold && st_nxt.w_hold && !st_nxt.bvalid) begin
            st_nxt.aw_hold = 1'b0;
            st_nxt.w_hold = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = RESP_OKAY;
            val = st_nxt.wdata[19:0];
            unique case (st_nxt.awaddr)
                ADDR_KEY_FUNC: begin
                    if (|st_nxt.wstrb) begin
                        st_nxt.func = st_nxt.wdata[9:0];
                        st_nxt.key = 1'b1;
                    end
                end
                ADDR_KEY_ENTER: begin
                    if (|st_nxt.wstrb) begin
                        st_nxt.entry = val;
                        st_nxt.key = 1'b1;
                        st_nxt.err = ERR_NONE;
                        if (st_r.func == FN_ACCESS) begin
                            entry_fire = 1'b1;
                            if (val == st_r.prog_code && st_r.jumper_s) begin
                                st_nxt.mode = MODE_PROGRAM;
                            end else if (val == SUPV_CODE && st_r.jumper_s) begin
                                st_nxt.mode = MODE_SUPERVISOR;
                            end else begin
                                st_nxt.mode = MODE_NORMAL;
                                if (!st_r.jumper_s) begin
                                    st_nxt.err = ERR_LOCKED;
                                end
                            end
                        end else if (st_r.func == FN_NEWCODE) begin
                            if (st_r.mode == MODE_SUPERVISOR) begin
                                st_nxt.prog_code = val;
                            end else begin
                                st_nxt.err = ERR_LOCKED;
                            end
                        end else if (st_r.mode == MODE_NORMAL) begin
                            st_nxt.err = ERR_LOCKED;
                        end else if (st_r.func == FN_TIMEOUT) begin
                            if (val >= 20'(TMO_MIN) && val <= 20'(TMO_MAX)) begin
                                st_nxt.tmo = val[9:0];
                            end else begin
                                st_nxt.err = ERR_RANGE;
                            end
                        end else begin
                            st_nxt.pv = 1'b1;
                            st_nxt.pfunc = st_r.func;
                            st_nxt.pdata = val;
                        end
                    end
                end
                ADDR_DISPLAY: begin
                    if (|st_nxt.wstrb) begin
                        st_nxt.show_pos = ~st_nxt.wdata[0];
                        st_nxt.key = 1'b1;
                    end
                end
                ADDR_STATUS, ADDR_TIMEOUT: begin
                end
                default: begin
                    st_nxt.bresp = RESP_SLVERR;
                end
            endcase
        end

        // Expiry beats a same-cycle key write; the next key restarts it anyway
        if (expire) begin
            st_nxt.mode = MODE_NORMAL;
            st_nxt.show_pos = 1'b1;
        end
        st_nxt.led = (st_nxt.mode != MODE_NORMAL);

        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st_r.arready) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = RESP_OKAY;
            st_nxt.rdata = '0;
            unique case (s_axi_araddr)
                ADDR_KEY_FUNC: st_nxt.rdata[9:0] = st_r.func;
                ADDR_KEY_ENTER: st_nxt.rdata[19:0] = st_r.entry;
                ADDR_STATUS: begin
                    st_nxt.rdata[ST_MODE_LSB +: 2] = st_r.mode;
                    st_nxt.rdata[ST_LED_BIT] = st_r.led;
                    st_nxt.rdata[ST_JUMPER_BIT] = st_r.jumper_s;
                    st_nxt.rdata[ST_DIGITS_LSB +: 3] = st_r.digits;
                    st_nxt.rdata[ST_SHOWPOS_BIT] = st_r.show_pos;
                    st_nxt.rdata[ST_ERR_LSB +: 4] = st_r.err;
                end
                ADDR_TIMEOUT: st_nxt.rdata[9:0] = st_r.tmo;
                ADDR_DISPLAY: st_nxt.rdata[0] = ~st_r.show_pos;
                default: st_nxt.rresp = RESP_SLVERR;
            endcase
        end
        st_nxt.awready = !st_nxt.aw_hold && !st_nxt.bvalid;
        st_nxt.wready = !st_nxt.w_hold && !st_nxt.bvalid;
        st_nxt.arready = !st_nxt.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
            st_r.prog_code <= PROG_CODE_RST;
            st_r.tmo <= TMO_RST;
            st_r.digits <= DIGITS_LOCKED;
            st_r.show_pos <= 1'b1;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign s_axi_awready = st_r.awready;
    assign s_axi_wready = st_r.wready;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_arready = st_r.arready;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rresp = st_r.rresp;
    assign s_axi_rdata = st_r.rdata;
    assign program_led = st_r.led;
    assign entry_digits = st_r.digits;
    assign show_position = st_r.show_pos;
    assign param_wr_valid = st_r.pv;
    assign param_func = st_r.pfunc;
    assign param_data = st_r.pdata;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_param_needs_mode: assert property (param_wr_valid |-> $past(st_r.mode) != MODE_NORMAL)
        else $error("parameter write passed in normal mode");
    a_lock_blocks_entry: assert property (
        (st_r.mode != MODE_NORMAL && $past(st_r.mode) == MODE_NORMAL) |-> $past(st_r.jumper_s))
        else $error("program mode entered without jumper");
    a_digits_follow: assert property (ce |=> entry_digits ==
        ($past(st_r.jumper_s) ? DIGITS_FULL : DIGITS_LOCKED))
        else $error("entry field width wrong");
    a_led_tracks_mode: assert property (program_led == (st_r.mode != MODE_NORMAL))
        else $error("program indicator disagrees with mode");
    a_mismatch_exit: assert property ((ce && entry_fire && val != st_r.prog_code
        && val != SUPV_CODE) |=> st_r.mode == MODE_NORMAL)
        else $error("bad access code kept mode");
    a_code_change_supv: assert property ($changed(st_r.prog_code) |->
        $past(st_r.mode) == MODE_SUPERVISOR)
        else $error("access code changed outside supervisory mode");
    a_expire_drops: assert property ((ce && expire) |=>
        st_r.mode == MODE_NORMAL && show_position)
        else $error("time-out did not drop mode or restore display");
    a_timeout_range: assert property (st_r.tmo >= TMO_MIN && st_r.tmo <= TMO_MAX)
        else $error("time-out setting out of range");
    a_bresp_holds: assert property ((s_axi_bvalid && !s_axi_bready) |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    a_rdata_holds: assert property ((s_axi_rvalid && !s_axi_rready) |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data changed before taken");
    a_bvalid_clears: assert property ((ce && s_axi_bvalid && s_axi_bready) |=> !s_axi_bvalid)
        else $error("write response repeated after handshake");
    a_lock_refuses_entry: assert property ((ce && entry_fire && !st_r.jumper_s) |=>
        st_r.mode == MODE_NORMAL && st_r.err == ERR_LOCKED)
        else $error("access entry accepted without jumper");
    a_supv_entry: assert property ((ce && entry_fire && !expire && st_r.jumper_s
        && val == SUPV_CODE && val != st_r.prog_code) |=> st_r.mode == MODE_SUPERVISOR)
        else $error("supervisory code did not give supervisory mode");
    a_tmo_set_rule: assert property ($changed(st_r.tmo) |->
        $past(st_r.func) == FN_TIMEOUT && $past(st_r.mode) != MODE_NORMAL)
        else $error("time-out setting changed outside its function");
    a_param_one_cycle: assert property ((ce && param_wr_valid) |=> !param_wr_valid)
        else $error("parameter write pulse longer than one cycle");
    a_access_no_param: assert property ((ce && entry_fire) |=> !param_wr_valid)
        else $error("access entry passed as parameter write");
    a_restart_clears: assert property ((ce && st_r.key) |=> !expire)
        else $error("time-out fired right after a key press");
endmodule

// ### pma_keypad.sv
// Keypad and display model that presses keys and reads the panel over AXI4-Lite
`timescale 1ns/1ps
module pma_keypad (
    // Clock
    input wire logic aclk,
    // Write channels
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    // Read channels
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end

    // Released payload is inverted so a stale value never looks valid
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wdata <= ~d;
            end
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                araddr <= ~a;
            end
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
endmodule

// ### test_program_mode_access_timer.sv
// Self-checking bench for the access control and inactivity timer
`timescale 1ns/1ps
module test_program_mode_access_timer;
    import pma_pkg::*;
    localparam int SEC = 4;
    logic aclk, aresetn, jp, ce;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, st;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, led, showp, pwv;
    logic [2:0] digits;
    logic [9:0] pfunc;
    logic [19:0] pdata;
    int bad_count, checks_done, npulse, mode, code, tmo, np, pf, pd, v;

    pma_access_ctrl #(.SEC_CYCLES(SEC)) DUT (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .program_lockout_jumper(jp), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .program_led(led), .entry_digits(digits), .show_position(showp),
        .param_wr_valid(pwv), .param_func(pfunc), .param_data(pdata));
    pma_keypad kp (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    always @(posedge aclk) if (pwv === 1'b1) npulse++;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Press function then value, update the model, compare state and outputs
    task automatic key(input int f, input int val);
        int err;
        kp.wr(ADDR_KEY_FUNC, f, r);
        kp.wr(ADDR_KEY_ENTER, val, r);
        err = 0;
        if (f == FN_ACCESS) begin
            if (jp && val == code) mode = 1;
            else if (jp && val == SUPV_CODE_DEF) mode = 2;
            else begin
                mode = 0;
                if (!jp) err = ERR_LOCKED;
            end
        end else if (f == FN_NEWCODE) begin
            if (mode == 2) code = val;
            else err = ERR_LOCKED;
        end else if (mode == 0) err = ERR_LOCKED;
        else if (f == FN_TIMEOUT) begin
            if (val >= TMO_MIN && val <= TMO_MAX) tmo = val;
            else err = ERR_RANGE;
        end else begin
            np++;
            pf = f;
            pd = val;
        end
        kp.rd(ADDR_STATUS, st, r);
        chk(st[1:0], mode);
        chk(led, mode != 0);
        chk(st[11:8], err);
        chk(npulse, np);
        if (np > 0) chk({pfunc, pdata}, {pf[9:0], pd[19:0]});
        kp.rd(ADDR_TIMEOUT, st, r);
        chk(st[9:0], tmo);
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        test_done();
    end

    initial begin
        jp = 1'b0;
        ce = 1'b1;
        aresetn = 1'b0;
        {mode, np, npulse, bad_count, checks_done} = '0;
        code = PROG_CODE_RST;
        tmo = TMO_RST;
        void'($urandom(32'hf9d0));
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        kp.rd(ADDR_TIMEOUT, st, r);
        chk(st[9:0], 120);
        chk({showp, led}, 2'h2);
        $display("test reset done");
        repeat (4) @(posedge aclk);
        chk(digits, DIGITS_LOCKED);
        key(FN_ACCESS, PROG_CODE_RST);
        key(300, 5);
        kp.wr(8'h20, 32'h0000_0001, r);
        chk(r, RESP_SLVERR);
        kp.rd(8'h24, st, r);
        chk(r, RESP_SLVERR);
        $display("test lockout done");
        jp <= 1'b1;
        repeat (4) @(posedge aclk);
        chk(digits, DIGITS_FULL);
        key(FN_ACCESS, PROG_CODE_RST);
        for (int i = 0; i < 3; i++) key(200 + $urandom % 100, $urandom % 20'hf_ffff);
        key(FN_NEWCODE, 1234);
        key(FN_TIMEOUT, 9);
        key(FN_TIMEOUT, 1001);
        key(FN_TIMEOUT, 1000);
        $display("test program done");
        key(FN_ACCESS, SUPV_CODE_DEF);
        v = 3000 + $urandom % 1000;
        key(FN_NEWCODE, v);
        key(FN_ACCESS, 1234);
        key(FN_ACCESS, PROG_CODE_RST);
        key(FN_ACCESS, v);
        key(FN_TIMEOUT, 10);
        $display("test supervisory done");
        kp.wr(ADDR_DISPLAY, 32'h0000_0001, r);
        repeat (25) @(posedge aclk);
        // Enable low must freeze the timer well past its time-out
        ce <= 1'b0;
        repeat (40) @(posedge aclk);
        ce <= 1'b1;
        chk({showp, led}, 2'h1);
        kp.wr(ADDR_DISPLAY, 32'h0000_0001, r);
        repeat (25) @(posedge aclk);
        chk({showp, led}, 2'h1);
        repeat (25) @(posedge aclk);
        chk({showp, led}, 2'h2);
        kp.rd(ADDR_STATUS, st, r);
        chk(st[1:0], MODE_NORMAL);
        $display("test timeout done");
        test_done();
    end
endmodule
